// *** hdl/dsef_pkg.sv ***
// Types of the security erase and freeze command block
package dsef_pkg;
  typedef enum logic [2:0] {
    DSEF_IDLE,
    DSEF_XFER,
    DSEF_CHECK,
    DSEF_ERASE,
    DSEF_DONE
  } dsef_state_t;
endpackage

// *** hdl/dsef_regs.svh ***
// Register offsets, field positions and constants of the security command block
`ifndef DSEF_REGS_SVH
`define DSEF_REGS_SVH
`define DSEF_OFF_CMD      8'h00
`define DSEF_OFF_DATA     8'h04
`define DSEF_OFF_ERR      8'h08
`define DSEF_OFF_STAT     8'h0C
`define DSEF_OFF_IRQSTAT  8'h10
`define DSEF_OFF_IRQMASK  8'h14
`define DSEF_OFF_CTRL     8'h18
`define DSEF_OFF_USERPW   8'h1C
`define DSEF_OFF_MASTPW   8'h20
`define DSEF_OFF_MAXLBA   8'h24
`define DSEF_OFF_ERATIME  8'h28
`define DSEF_OFF_SECSTAT  8'h2C
`define DSEF_OP_SETPW     8'hF1
`define DSEF_OP_UNLOCK    8'hF2
`define DSEF_OP_PREP      8'hF3
`define DSEF_OP_ERASE     8'hF4
`define DSEF_OP_FREEZE    8'hF5
`define DSEF_OP_DISPW     8'hF6
`define DSEF_ERR_ABT      2
`define DSEF_ST_BSY       7
`define DSEF_ST_RDY       6
`define DSEF_ST_DF        5
`define DSEF_ST_DSC       4
`define DSEF_ST_DRQ       3
`define DSEF_ST_ERR       0
`define DSEF_W0_ID        0
`define DSEF_W0_MODE      1
`define DSEF_PW_WORDS     16
`define DSEF_SECT_WORDS   256
`define DSEF_PW_FIRST     9'h001
`define DSEF_PW_LAST      9'h010
`define DSEF_IRQ_DONE     0
`define DSEF_IRQ_ABORT    1
`define DSEF_IRQ_DRQ      2
`define DSEF_MAXLBA_RST   32'h0000FFFF
`define DSEF_ERATIME_RST  16'h0001
`endif

// *** hdl/dsef_security_cmd.sv ***
// Security erase-unit and freeze-lock command logic with AHB-Lite registers
//
// Functional notes
// - Opcode F4h starts erase-unit
// - Erase all sectors, then disable lock
// - Erase LBA 0 to native max
// - Host sends exactly one parameter sector
// - Security disabled with user id aborts
// - Password mismatch aborts the erase
// - Word0 bit0 identifier, bit1 mode; password follows
// - Identifier selects user or master password
// - Write zeros, no read-back verify
// - Defect and reassign lists untouched
// - Erase needs prepare immediately before
// - Master password kept after erase
// - Lock disabled with master id: skip compare, just erase
// - Erase time reported as identify word 89
// - Opcode F5h freezes immediately
// - Frozen rejects security-changing commands
// - Frozen clears only at power removal
// - Prepare has no data transfer
`timescale 1ns/10ps
`include "dsef_regs.svh"
module dsef_security_cmd (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        powerOnRst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Media write engine
  output logic             mediaWrite,
  output logic      [31:0] mediaLba,
  input  wire logic        mediaDone,
  // Interrupt
  output logic             irq
);
  logic [31:0] userPw [`DSEF_PW_WORDS];
  logic [31:0] mastPw [`DSEF_PW_WORDS];
  logic [31:0] rxPw   [`DSEF_PW_WORDS];
  logic [7:0]  errReg;
  logic [7:0]  statReg;
  logic [2:0]  irqStat;
  logic [2:0]  irqMask;
  logic        lockEnabled;
  logic        frozen;
  logic        prepArmed;
  logic        idUseMaster;
  logic [31:0] nativeMaxLba;
  logic [15:0] eraseTime;
  logic [8:0]  wordCnt;
  logic [4:0]  pwWr;
  logic        pwSelMaster;
  logic        dphWrite;
  logic [7:0]  dphAddr;
  logic        mediaSync1;
  logic        mediaSync2;
  logic        mediaSyncOld;
  dsef_pkg::dsef_state_t state;
  dsef_pkg::dsef_state_t next_state;

  function automatic logic [7:0] abortFlags(input logic dummy);
    abortFlags = 8'h00;
    abortFlags[`DSEF_ERR_ABT] = ~dummy | dummy;
  endfunction

  // Write strobe of one register in its data phase
  function automatic logic wrHit(input logic w, input logic [7:0] a,
                                 input logic [7:0] off);
    wrHit = w & (a == off);
  endfunction

  // Address phase capture; every access completes with no wait state
  wire addrValid = hsel & hready & htrans[1];
  wire wrCmd     = wrHit(dphWrite, dphAddr, `DSEF_OFF_CMD);
  wire wrData    = wrHit(dphWrite, dphAddr, `DSEF_OFF_DATA);
  wire wrIrqClr  = wrHit(dphWrite, dphAddr, `DSEF_OFF_IRQSTAT);
  wire wrIrqMask = wrHit(dphWrite, dphAddr, `DSEF_OFF_IRQMASK);
  wire wrCtrl    = wrHit(dphWrite, dphAddr, `DSEF_OFF_CTRL);
  wire wrUserPw  = wrHit(dphWrite, dphAddr, `DSEF_OFF_USERPW);
  wire wrMastPw  = wrHit(dphWrite, dphAddr, `DSEF_OFF_MASTPW);
  wire wrMaxLba  = wrHit(dphWrite, dphAddr, `DSEF_OFF_MAXLBA);
  wire wrEraTime = wrHit(dphWrite, dphAddr, `DSEF_OFF_ERATIME);
  wire [7:0] opcode = hwdata[7:0];
  wire idle      = (state == dsef_pkg::DSEF_IDLE);
  wire cmdErase  = wrCmd & idle & (opcode == `DSEF_OP_ERASE);
  wire cmdFreeze = wrCmd & idle & (opcode == `DSEF_OP_FREEZE);
  wire cmdPrep   = wrCmd & idle & (opcode == `DSEF_OP_PREP);
  wire cmdGuard  = (opcode == `DSEF_OP_SETPW) | (opcode == `DSEF_OP_UNLOCK)
                 | (opcode == `DSEF_OP_DISPW) | (opcode == `DSEF_OP_ERASE);
  wire frozenRej = wrCmd & idle & frozen & cmdGuard;
  // Erase without a prepare just before it is refused
  wire noPrepRej = cmdErase & ~frozen & ~prepArmed;
  wire otherCmd  = wrCmd & idle & ~cmdErase & ~cmdFreeze & ~cmdPrep
                 & ~frozenRej;
  wire xferWord  = (state == dsef_pkg::DSEF_XFER) & wrData;
  wire xferLast  = xferWord & (wordCnt == 9'(`DSEF_SECT_WORDS - 1));
  // Compare selected password word by word; all 64 bytes matter
  logic pwMatch;
  always_comb begin
    pwMatch = 1'b1;
    for (int i = 0; i < `DSEF_PW_WORDS; i++) begin
      if (rxPw[i] != (idUseMaster ? mastPw[i] : userPw[i])) begin
        pwMatch = 1'b0;
      end
    end
  end
  wire userIdOff = ~lockEnabled & ~idUseMaster;
  wire chkAbort  = userIdOff | (lockEnabled & ~pwMatch);
  wire chkAbortV = (state == dsef_pkg::DSEF_CHECK) & chkAbort;
  wire mediaEdge = mediaSync2 & ~mediaSyncOld;
  wire eraseLast = mediaEdge & (mediaLba == nativeMaxLba);
  wire doneEv    = (state == dsef_pkg::DSEF_ERASE) & eraseLast;
  wire eraseStep = mediaEdge & (state == dsef_pkg::DSEF_ERASE) & ~eraseLast;
  wire abortEv   = frozenRej | noPrepRej | chkAbortV;
  // Freeze, and prepare when not frozen, complete at once and count as done
  wire evDrq     = cmdErase & ~abortEv;
  wire evDone    = doneEv | cmdFreeze | (cmdPrep & ~frozen);
  wire [2:0] irqEvents = (3'(evDone) << `DSEF_IRQ_DONE)
                       | (3'(abortEv) << `DSEF_IRQ_ABORT)
                       | (3'(evDrq) << `DSEF_IRQ_DRQ);
  // Status images; ready and seek-complete are set in every image but busy
  wire [7:0] statIdle  = 8'(1 << `DSEF_ST_RDY) | 8'(1 << `DSEF_ST_DSC);
  wire [7:0] statDrq   = statIdle | 8'(1 << `DSEF_ST_DRQ);
  wire [7:0] statBusy  = 8'(1 << `DSEF_ST_BSY);
  wire [7:0] statAbort = statIdle | 8'(1 << `DSEF_ST_ERR);

  // Commands that arrive outside idle are ignored, not queued
  always_comb begin
    next_state = state;
    unique case (state)
      dsef_pkg::DSEF_IDLE:
        if (cmdErase & ~frozen & prepArmed) next_state = dsef_pkg::DSEF_XFER;
      dsef_pkg::DSEF_XFER:
        if (xferLast) next_state = dsef_pkg::DSEF_CHECK;
      dsef_pkg::DSEF_CHECK:
        next_state = chkAbort ? dsef_pkg::DSEF_DONE : dsef_pkg::DSEF_ERASE;
      dsef_pkg::DSEF_ERASE:
        if (eraseLast) next_state = dsef_pkg::DSEF_DONE;
      dsef_pkg::DSEF_DONE:
        next_state = dsef_pkg::DSEF_IDLE;
    endcase
  end

  // A write lands one cycle after its address phase
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dphWrite <= 1'b0;
      dphAddr  <= 8'h00;
    end else begin
      dphWrite <= addrValid & hwrite;
      dphAddr  <= haddr[7:0];
    end
  end

  // Frozen clears only on power-on reset, not the ordinary reset
  always_ff @(posedge core_clk) begin
    if (powerOnRst) begin
      frozen <= 1'b0;
    end else if (cmdFreeze) begin
      frozen <= 1'b1;
    end
  end

  // Only the ordinary reset returns the sequencer to idle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= dsef_pkg::DSEF_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Prepare carries no data: it only arms the next command
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prepArmed <= 1'b0;
    end else if (wrCmd & idle) begin
      prepArmed <= cmdPrep & ~frozen;
    end
  end

  // Word 0 holds the identifier, words 1 to 16 the password
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wordCnt     <= 9'h000;
      idUseMaster <= 1'b0;
    end else if (cmdErase) begin
      wordCnt <= 9'h000;
    end else if (xferWord) begin
      wordCnt <= wordCnt + 9'h001;
      if (wordCnt == 9'h000) begin
        // Enhanced mode bit is ignored: normal erase only
        idUseMaster <= hwdata[`DSEF_W0_ID];
      end
    end
  end

  // One capture register per password word
  generate
    for (genvar g = 0; g < `DSEF_PW_WORDS; g++) begin : gPw
      always_ff @(posedge core_clk) begin
        if (rst) begin
          rxPw[g] <= 32'h00000000;
        end else if (xferWord & (wordCnt == 9'(g + 1))) begin
          rxPw[g] <= hwdata;
        end
      end
    end
  endgenerate

  // Stored passwords: master is never cleared by erase
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pwWr <= 5'h00;
      pwSelMaster <= 1'b0;
    end else if (wrUserPw | wrMastPw) begin
      pwWr <= (pwSelMaster == wrMastPw) ? pwWr + 5'h01 : 5'h01;
      pwSelMaster <= wrMastPw;
    end
  end

  // Writing the other window restarts at word 0
  always_ff @(posedge core_clk) begin
    if (wrUserPw) begin
      userPw[(pwSelMaster == 1'b0) ? pwWr[3:0] : 4'h0] <= hwdata;
    end
    if (wrMastPw) begin
      mastPw[(pwSelMaster == 1'b1) ? pwWr[3:0] : 4'h0] <= hwdata;
    end
  end

  // Lock enable is loaded by software; set-password lies outside here
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lockEnabled  <= 1'b0;
      nativeMaxLba <= `DSEF_MAXLBA_RST;
      eraseTime    <= `DSEF_ERATIME_RST;
    end else begin
      if (doneEv) begin
        lockEnabled <= 1'b0;
      end else if (wrCtrl) begin
        lockEnabled <= hwdata[0];
      end
      if (wrMaxLba) nativeMaxLba <= hwdata;
      if (wrEraTime) eraseTime <= hwdata[15:0];
    end
  end

  // Media engine handshake; done may come from another domain
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mediaSync1   <= 1'b0;
      mediaSync2   <= 1'b0;
      mediaSyncOld <= 1'b0;
      mediaWrite   <= 1'b0;
      mediaLba     <= 32'h00000000;
    end else begin
      mediaSync1   <= mediaDone;
      mediaSync2   <= mediaSync1;
      mediaSyncOld <= mediaSync2;
      // Zero-fill writes only, no read-back; defect lists untouched
      mediaWrite <= (next_state == dsef_pkg::DSEF_ERASE);
      if (state == dsef_pkg::DSEF_CHECK) begin
        mediaLba <= 32'h00000000;
      end else if (eraseStep) begin
        mediaLba <= mediaLba + 32'h00000001;
      end
    end
  end

  // Abort outranks every other status update
  always_ff @(posedge core_clk) begin
    if (rst) begin
      errReg  <= 8'h00;
      statReg <= statIdle;
    end else if (abortEv) begin
      errReg  <= abortFlags(1'b0);
      statReg <= statAbort;
    end else if (cmdErase | cmdPrep | cmdFreeze | otherCmd) begin
      errReg  <= 8'h00;
      statReg <= cmdErase ? statDrq : statIdle;
    end else if (xferLast) begin
      statReg <= statBusy;
    end else if (doneEv) begin
      statReg <= statIdle;
    end
  end

  // A new event wins over a clear of the same bit
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irqStat <= 3'h0;
      irqMask <= 3'h0;
      irq     <= 1'b0;
    end else begin
      irqStat <= (irqStat & ~(wrIrqClr ? hwdata[2:0] : 3'h0)) | irqEvents;
      if (wrIrqMask) irqMask <= hwdata[2:0];
      irq <= |(irqStat & irqMask);
    end
  end

  // Read data is fetched in the address phase to stand in the data phase;
  // a read right behind a write to the same register returns the old value
  function automatic logic [31:0] readWord(input logic [7:0] a);
    unique case (a)
      `DSEF_OFF_ERR:     readWord = {24'h000000, errReg};
      `DSEF_OFF_STAT:    readWord = {24'h000000, statReg};
      `DSEF_OFF_IRQSTAT: readWord = {29'h00000000, irqStat};
      `DSEF_OFF_IRQMASK: readWord = {29'h00000000, irqMask};
      `DSEF_OFF_CTRL:    readWord = {31'h00000000, lockEnabled};
      `DSEF_OFF_MAXLBA:  readWord = nativeMaxLba;
      `DSEF_OFF_ERATIME: readWord = {16'h0000, eraseTime};
      `DSEF_OFF_SECSTAT: readWord = {29'h00000000, prepArmed, frozen,
                                     lockEnabled};
      default:           readWord = 32'h00000000;
    endcase
  endfunction

  // Zero wait states and an OKAY response on every transfer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hrdata    <= (addrValid & ~hwrite) ? readWord(haddr[7:0]) : hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
endmodule

// *** sim/dsef_chk.sv ***
// Port checker of the security command block
`timescale 1ns/10ps
`include "dsef_regs.svh"
module dsef_chk (
  // Clock and resets
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        powerOnRst,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Media and interrupt
  input wire logic        mediaWrite,
  input wire logic [31:0] mediaLba,
  input wire logic        irq
);
  logic       cmdPhase;
  logic [7:0] lastOp;
  logic [7:0] prevOp;
  logic       frozen;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence seq_cmd_addr;
    hsel && hready && htrans[1] && hwrite && haddr[7:0] == `DSEF_OFF_CMD;
  endsequence
  sequence seq_cmd(op);
    seq_cmd_addr ##1 hwdata[7:0] == op;
  endsequence
  always_ff @(posedge core_clk) begin
    cmdPhase <= !rst && hsel && hready && htrans[1] && hwrite
                && haddr[7:0] == `DSEF_OFF_CMD;
  end
  // Only the last two commands matter for the prepare gate
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lastOp <= 8'h00;
      prevOp <= 8'h00;
    end else if (cmdPhase) begin
      prevOp <= lastOp;
      lastOp <= hwdata[7:0];
    end
  end
  // Plain reset must not thaw the frozen state
  always_ff @(posedge core_clk) begin
    if (powerOnRst) frozen <= 1'b0;
    else if (cmdPhase && hwdata[7:0] == `DSEF_OP_FREEZE) frozen <= 1'b1;
  end
  chk_ready_high: assert property (hreadyout)
    else $error("hreadyout dropped");
  chk_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  chk_reset_quiet: assert property ($fell(rst) |-> !mediaWrite && !irq)
    else $error("outputs active after reset");
  chk_lba_start: assert property (
    $rose(mediaWrite) |-> mediaLba == 32'h0)
    else $error("erase does not start at block zero");
  chk_lba_step: assert property (
    mediaWrite && $past(mediaWrite) && $changed(mediaLba)
    |-> mediaLba == $past(mediaLba) + 32'h1)
    else $error("erase skipped a block");
  chk_erase_waits: assert property (
    seq_cmd(`DSEF_OP_ERASE) |-> !mediaWrite [*8])
    else $error("erase began before the parameter sector");
  chk_prep_needed: assert property (
    $rose(mediaWrite) |-> lastOp == `DSEF_OP_ERASE
    && prevOp == `DSEF_OP_PREP)
    else $error("erase without preceding prepare");
  chk_frozen_block: assert property (
    frozen |-> !$rose(mediaWrite))
    else $error("erase ran while frozen");
endmodule
bind dsef_security_cmd dsef_chk dsef_chk_i (
  .core_clk(core_clk), .rst(rst), .powerOnRst(powerOnRst),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout),
  .hresp(hresp), .mediaWrite(mediaWrite), .mediaLba(mediaLba),
  .irq(irq));

// *** sim/dsef_media_model.sv ***
// Media write engine stand-in that acknowledges each zeroed block
`timescale 1ns/10ps
module dsef_media_model (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // Engine side
  input wire logic        mediaWrite,
  input wire logic [31:0] mediaLba,
  input wire logic        slow,
  output logic            mediaDone,
  output logic     [31:0] doneCount,
  output logic     [31:0] lastLba
);
  logic [4:0] tmr;
  logic [4:0] gap;
  // Gap leaves room for the two-stage synchroniser before the next pulse
  assign gap = slow ? 5'h0C : 5'h04;
  always_ff @(posedge core_clk) begin
    if (rst || !mediaWrite) tmr <= 5'h00;
    else if (tmr == gap + 5'h05) tmr <= 5'h00;
    else tmr <= tmr + 5'h01;
  end
  always_ff @(posedge core_clk) begin
    mediaDone <= !rst && mediaWrite && tmr >= gap && tmr < gap + 5'h03;
    if (rst) begin
      doneCount <= 32'h0;
      lastLba   <= 32'h0;
    end else if (mediaWrite && tmr == gap) begin
      doneCount <= doneCount + 32'h1;
      lastLba   <= mediaLba;
    end
  end
endmodule

// *** sim/dsef_security_cmd_test.sv ***
// Self-checking bench of the erase and freeze commands
`timescale 1ns/10ps
`include "dsef_regs.svh"
module dsef_security_cmd_test;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        powerOnRst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        slow = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hrdata, mediaLba, doneCount, lastLba;
  logic        hreadyout, hresp, mediaWrite, mediaDone, irq;
  int          fails = 0;
  int          checks_done = 0;
  always #50 core_clk = ~core_clk;
  dsef_security_cmd dsef_security_cmd_i (.core_clk(core_clk), .rst(rst),
    .powerOnRst(powerOnRst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .mediaWrite(mediaWrite), .mediaLba(mediaLba), .mediaDone(mediaDone),
    .irq(irq));
  dsef_media_model dsef_media_model_i (.core_clk(core_clk), .rst(rst),
    .mediaWrite(mediaWrite), .mediaLba(mediaLba), .slow(slow),
    .mediaDone(mediaDone), .doneCount(doneCount), .lastLba(lastLba));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    xfer(1'b0, a, 32'h0, r);
  endtask
  task automatic irq_is(input string what, input logic [7:0] m, input logic e);
    wr(`DSEF_OFF_IRQMASK, {24'h0, m});
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    check(what, {31'h0, e}, {31'h0, irq});
    @(posedge core_clk);
  endtask
  task automatic erase(input logic p, input logic [31:0] id, pw,
                       input logic abt, input logic [31:0] secs);
    int          n;
    logic [31:0] base;
    logic [31:0] r;
    base = doneCount;
    if (p) wr(`DSEF_OFF_CMD, {24'h0, `DSEF_OP_PREP});
    // Prepare raises the done event itself unless frozen; drop it before the erase
    wr(`DSEF_OFF_IRQSTAT, 32'h7);
    wr(`DSEF_OFF_CMD, {24'h0, `DSEF_OP_ERASE});
    for (n = 0; n < `DSEF_SECT_WORDS; n++)
      wr(`DSEF_OFF_DATA, n == 0 ? id : n <= `DSEF_PW_WORDS ? pw + n : 32'h0);
    wr(`DSEF_OFF_IRQMASK, 32'h3);
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (irq !== 1'b1 && n < 5000);
    check("event raised", 32'h1, {31'h0, irq});
    @(posedge core_clk);
    rd(`DSEF_OFF_ERR, r);
    check("error flags", abt ? 32'h4 : 32'h0, r);
    rd(`DSEF_OFF_STAT, r);
    check("status flags", abt ? 32'h51 : 32'h50, r);
    if (!abt) begin
      rd(`DSEF_OFF_CTRL, r);
      check("lock after erase", 32'h0, r);
    end
    irq_is("abort event", 8'h02, abt);
    irq_is("done event", 8'h01, !abt);
    wr(`DSEF_OFF_IRQSTAT, 32'h7);
    irq_is("events cleared", 8'h03, 1'b0);
    check("blocks zeroed", secs, doneCount - base);
    if (secs != 0) check("last block", secs - 32'h1, lastLba);
  endtask
  initial begin
    repeat (40000) @(posedge core_clk);
    fails++;
    stop_test;
  end
  initial begin
    logic [31:0] r;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    powerOnRst <= 1'b0;
    @(posedge core_clk);
    xfer(1'b0, 8'h40, 32'h0, r);
    check("unmapped read", 32'h0, r);
    wr(`DSEF_OFF_MAXLBA, 32'h3);
    wr(`DSEF_OFF_ERATIME, 32'h5A);
    rd(`DSEF_OFF_ERATIME, r);
    check("erase time", 32'h5A, r);
    for (int i = 1; i <= 16; i++) wr(`DSEF_OFF_USERPW, 32'h1000 + i);
    for (int i = 1; i <= 16; i++) wr(`DSEF_OFF_MASTPW, 32'h3000 + i);
    wr(`DSEF_OFF_CTRL, 32'h1);
    erase(1'b0, 32'h0, 32'h1000, 1'b1, 32'h0);
    erase(1'b1, 32'h0, 32'h2000, 1'b1, 32'h0);
    slow <= 1'b1;
    erase(1'b1, 32'h0, 32'h1000, 1'b0, 32'h4);
    wr(`DSEF_OFF_CTRL, 32'h1);
    erase(1'b1, 32'h1, 32'h3000, 1'b0, 32'h4);
    slow <= 1'b0;
    erase(1'b1, 32'h0, 32'h1000, 1'b1, 32'h0);
    erase(1'b1, 32'h1, 32'h2000, 1'b0, 32'h4);
    wr(`DSEF_OFF_CMD, {24'h0, `DSEF_OP_FREEZE});
    rd(`DSEF_OFF_SECSTAT, r);
    check("frozen state", 32'h2, r);
    erase(1'b1, 32'h1, 32'h3000, 1'b1, 32'h0);
    rst <= 1'b1;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    erase(1'b1, 32'h1, 32'h3000, 1'b1, 32'h0);
    rd(`DSEF_OFF_SECSTAT, r);
    check("frozen after reset", 32'h2, r);
    stop_test;
  end
endmodule
